// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import tpio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_i;
    logic [7:0] drv_en = 8'h00;
    logic [7:0] drv_val = 8'h00;
    tpio_pins_t pins_r;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] seed = 16'h2e26;
    logic [31:0] q, a, t, ctab[6];
    logic e;
    logic [7:0] cw;

    always #25 clk = ~clk;

    tpio_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_i(pin_i), .pins_r(pins_r));
    tpio_ext_dev ext (.pins_r(pins_r), .drv_en(drv_en), .drv_val(drv_val), .pin_i(pin_i));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Reference pin model: {driven levels, enables}; port A wins pins 0..3
    function automatic logic [15:0] exp_pins(input logic [31:0] c, input logic [31:0] w);
        logic [7:0] o, oe;
        o = 8'h00;
        oe = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if ((i < 4 && c[0]) ? c[3] : (c[1] && c[4])) begin
                oe[i] = ((i < 4 && c[0]) ? c[5] : c[6]) ? !w[i] : 1'b1;
                o[i] = oe[i] & w[i];
            end
        end
        return c[2] ? 16'h0000 : {o, oe};
    endfunction

    task automatic stop_test;
        $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h want %h", $time, m, s, x);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(32'(n), 32'h0000_0001, "bus latency");
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, ad, d, r, er);
    endtask

    task automatic rd(input logic [11:0] ad, output logic [31:0] r);
        logic er;
        apb(1'b0, ad, 32'h0000_0000, r, er);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            rd(OFF_STAT, q);
            n++;
        end while (q[0] !== 1'b1 && n < 100);
        chk({31'h0, q[0]}, 32'h0000_0001, "done seen");
        repeat (2) @(posedge clk);
    endtask

    task automatic out_case(input logic [31:0] c, input logic [31:0] w);
        wr(OFF_CTRL, c);
        wr(OFF_DATA, w);
        wait_done();
        chk({16'h0000, pins_r.o & pins_r.oe, pins_r.oe}, {16'h0000, exp_pins(c, w)}, "pins");
        $display("Test output ctrl %h done", c);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        ctab = '{32'h0000_0009, 32'h0000_0029, 32'h0000_0013, 32'h0000_001b,
                 32'h0000_0052, 32'h0000_001f};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(OFF_CTRL, q);
        chk(q, CTRL_RST, "ctrl reset");
        rd(OFF_ID, q);
        chk(q, ID_VALUE, "id");
        apb(1'b0, 12'h0fc, 32'h0000_0000, q, e);
        chk({q[31:1], e}, 32'h0000_0001, "unmapped");
        $display("Test registers done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            out_case(ctab[i], {16'h0000, seed});
        end
        seed = lfsr(seed);
        wr(OFF_COND, {24'h00_0000, seed[7:0]});
        cw = seed[7:0];
        drv_en <= 8'hff;
        drv_val <= ~seed[7:0];
        wr(OFF_CTRL, 32'h0000_0082);
        wr(OFF_DATA, 32'h0000_0000);
        rd(OFF_STAT, q);
        chk({31'h0, q[1]}, 32'h0000_0001, "waiting");
        drv_val <= seed[7:0];
        wait_done();
        rd(OFF_DATA, q);
        chk({24'h00_0000, q[7:0]}, {24'h00_0000, seed[7:0]}, "sampled");
        rd(OFF_STAT, q);
        chk({31'h0, q[0]}, 32'h0000_0000, "done cleared");
        drv_en <= 8'h00;
        $display("Test conditional input done");
        wr(OFF_CTRL, 32'h0000_0009);
        rd(OFF_COUNT, a);
        rd(OFF_COUNT, q);
        chk({16'h0000, q[15:0] - a[15:0]}, 32'h0000_0003, "ref count");
        wr(OFF_CLKDIV, 32'h0001_0003);
        wr(OFF_CTRL, 32'h0000_1009);
        rd(OFF_COUNT, a);
        repeat (3) rd(OFF_ID, q);
        rd(OFF_COUNT, q);
        chk({16'h0000, q[15:0] - a[15:0]}, 32'h0000_0003, "div count");
        $display("Test counters done");
        wr(OFF_CTRL, 32'h0000_0112);
        rd(OFF_COUNT, a);
        t = {16'h0000, a[15:0] + 16'h0028};
        wr(OFF_TIME, t);
        seed = lfsr(seed);
        wr(OFF_DATA, {16'h0000, seed});
        rd(OFF_STAT, q);
        chk({31'h0, q[1]}, 32'h0000_0001, "timed pending");
        chk({16'h0000, pins_r.o & pins_r.oe, pins_r.oe},
            {16'h0000, exp_pins(32'h0000_0112, {24'h00_0000, cw})}, "held pins");
        wait_done();
        rd(OFF_STAMP, q);
        chk({16'h0000, q[15:0]}, t, "stamp");
        chk({16'h0000, pins_r.o & pins_r.oe, pins_r.oe},
            {16'h0000, exp_pins(32'h0000_0112, {16'h0000, seed})}, "timed pins");
        $display("Test timed output done");
        // Serial word leaves LSB first on pin 0, one bit per reference tick
        wr(OFF_CTRL, 32'h0000_0212);
        seed = lfsr(seed);
        wr(OFF_DATA, {16'h0000, seed});
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            a[i] = pins_r.o[0];
            @(posedge clk);
        end
        chk({24'h00_0000, a[7:0]}, {24'h00_0000, seed[7:0]}, "serial bits");
        $display("Test serial output done");
        stop_test();
    end
endmodule

// ===== tpio_ext_dev.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// External devices on the eight pins
// ------------------------------------------------------------
module tpio_ext_dev
    import tpio_pkg::*;
(
    input wire tpio_pkg::tpio_pins_t pins_r,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] drv_val,
    output logic [7:0] pin_i
);
    // Released pins with drv_en low fall to the pad pull-down, never keep the last value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pins_r.oe[i]) begin
                pin_i[i] = pins_r.o[i];
            end else begin
                pin_i[i] = drv_en[i] ? drv_val[i] : 1'b0;
            end
        end
    end
endmodule

// ===== tpio_pkg.sv
package tpio_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_DATA = 12'h004;
    localparam logic [11:0] OFF_TIME = 12'h008;
    localparam logic [11:0] OFF_STAMP = 12'h00C;
    localparam logic [11:0] OFF_COUNT = 12'h010;
    localparam logic [11:0] OFF_STAT = 12'h014;
    localparam logic [11:0] OFF_COND = 12'h018;
    localparam logic [11:0] OFF_PIN = 12'h01C;
    localparam logic [11:0] OFF_CLKDIV = 12'h020;
    localparam logic [11:0] OFF_ID = 12'h024;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_EN_A = 0;
    localparam int CTL_EN_B = 1;
    localparam int CTL_LINK = 2;
    localparam int CTL_OUT_A = 3;
    localparam int CTL_OUT_B = 4;
    localparam int CTL_OC_A = 5;
    localparam int CTL_OC_B = 6;
    localparam int CTL_WAIT = 7;
    localparam int CTL_TIMED = 8;
    localparam int CTL_SERIAL = 9;
    localparam int CTL_CB_LSB = 12;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int NUM_CB = 6;
    localparam logic [15:0] CB_DIV_RST = 16'h0000;
    // Arbitrary identity value
    localparam logic [31:0] ID_VALUE = 32'h1234_5678;
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } tpio_pins_t;
endpackage

// ===== tpio_top.sv
`timescale 1ns/10ps
// How it works
// RULE_01: Port direction is one bit for all pins
// RULE_02: Drive pins or sample, optionally awaiting condition
// RULE_03: Core accesses finish in one cycle
// RULE_04: Open collector drives low, releases one
// RULE_05: Shift stage plus transfer register per port; only port B has them, port A drives from txd_r
// RULE_06: Sixteen bit counter times each transfer
// RULE_07: Counter readable; transfers scheduled at value
// RULE_08: Counter captured as timestamp on transfer
// RULE_09: Enabled link disables ports on its pins
// RULE_10: Narrow port owns pins shared with wide
// RULE_11: Unshared wide pins stay with wide port
// RULE_12: Ports always move full nominal width
// RULE_13: Clock blocks set each port rate; the one shared select paces port B only, port A pins follow txd_r
// RULE_14: Six clock blocks, first is reference
// RULE_15: Counter ticks per clock block, wraps
// RULE_16: Timed transfer fires on matching tick
module tpio_top #(
    parameter int WA = 4,
    parameter int WB = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [WB-1:0] pin_i,
    output tpio_pkg::tpio_pins_t pins_r
);
    import tpio_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rs1_r, rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_sync_n <= rs1_r;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [WB-1:0] txd_r;
    logic [15:0] time_r;
    logic [WB-1:0] cond_r;
    logic [15:0] div_r [NUM_CB];
    logic [15:0] cbcnt_r [NUM_CB];
    logic [NUM_CB-1:0] tick;
    logic [15:0] count_r;
    logic [15:0] stamp_r;
    logic [WB-1:0] xfer_r;
    logic [WB-1:0] shift_r;
    logic [3:0] scnt_r;
    logic pend_r;
    logic done_r;
    logic ack_done;

    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    wire known = (paddr <= OFF_ID) && (paddr[1:0] == 2'b00);

    // Single-cycle access phase: no wait states
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable; // RULE_03
        end
    end
    wire acc = pready;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_r <= CTRL_RST;
            txd_r <= '0;
            time_r <= '0;
            cond_r <= '0;
        end else if (wr && acc) begin
            unique case (paddr)
                OFF_CTRL: ctrl_r <= pwdata;
                OFF_DATA: txd_r <= pwdata[WB-1:0];
                OFF_TIME: time_r <= pwdata[15:0];
                OFF_COND: cond_r <= pwdata[WB-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clock blocks: block 0 is the reference, ticking every cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < NUM_CB; i++) begin
                div_r[i] <= CB_DIV_RST;
                cbcnt_r[i] <= '0;
            end
        end else begin
            for (int i = 1; i < NUM_CB; i++) begin // RULE_14
                if (wr && acc && paddr == OFF_CLKDIV && pwdata[18:16] == 3'(i)) begin
                    div_r[i] <= pwdata[15:0];
                end
                cbcnt_r[i] <= (cbcnt_r[i] >= div_r[i]) ? 16'h0000 : cbcnt_r[i] + 16'h0001;
            end
        end
    end
    always_comb begin
        tick[0] = 1'b1;
        for (int i = 1; i < NUM_CB; i++) begin
            tick[i] = (cbcnt_r[i] >= div_r[i]);
        end
    end
    logic [2:0] cbsel;
    assign cbsel = (ctrl_r[CTL_CB_LSB+:3] < 3'(NUM_CB)) ? ctrl_r[CTL_CB_LSB+:3] : 3'd0;
    wire ptick = tick[cbsel]; // RULE_13

    // ------------------------------------------------------------
    // Port counter, transfer and shift stage (port B)
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_r <= '0;
        end else if (ptick) begin
            count_r <= count_r + 16'h0001; // RULE_06 RULE_15
        end
    end

    wire armed = wr && acc && paddr == OFF_DATA;
    wire outb = ctrl_r[CTL_OUT_B]; // RULE_01
    wire time_ok = !ctrl_r[CTL_TIMED] || (count_r == time_r); // RULE_16
    wire cond_ok = !ctrl_r[CTL_WAIT] || outb || (pin_i == cond_r); // RULE_02
    wire fire = pend_r && ptick && time_ok && cond_ok;
    assign ack_done = rd && acc && paddr == OFF_STAT;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_r <= 1'b0;
        end else if (armed) begin
            pend_r <= 1'b1;
        end else if (fire) begin
            pend_r <= 1'b0;
        end
    end

    // Done flag: new transfer wins over a clearing read
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_r <= 1'b0;
        end else if (fire) begin
            done_r <= 1'b1;
        end else if (ack_done) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stamp_r <= '0;
            xfer_r <= '0;
        end else if (fire) begin
            stamp_r <= count_r; // RULE_07 RULE_08
            xfer_r <= outb ? txd_r : pin_i; // RULE_05 RULE_12
        end
    end

    // Serial mode shifts the transfer word out LSB first on bit 0
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            shift_r <= '0;
            scnt_r <= '0;
        end else if (fire) begin
            shift_r <= outb ? txd_r : pin_i;
            scnt_r <= 4'(WB);
        end else if (ptick && scnt_r != 4'h0) begin
            shift_r <= {1'b0, shift_r[WB-1:1]}; // RULE_05
            scnt_r <= scnt_r - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Pin ownership: link over narrow port over wide port
    // ------------------------------------------------------------
    logic [WB-1:0] val_b, drv_o, drv_oe;
    logic [WA-1:0] val_a;
    assign val_b = ctrl_r[CTL_SERIAL] ? {{(WB-1){1'b1}}, shift_r[0]} : xfer_r;
    assign val_a = txd_r[WA-1:0];
    always_comb begin
        drv_o = '0;
        drv_oe = '0;
        for (int i = 0; i < WB; i++) begin
            if (ctrl_r[CTL_LINK]) begin
                drv_oe[i] = 1'b0; // RULE_09
            end else if (i < WA && ctrl_r[CTL_EN_A]) begin // RULE_10
                drv_o[i] = val_a[i];
                drv_oe[i] = ctrl_r[CTL_OUT_A] & ~(ctrl_r[CTL_OC_A] & val_a[i]); // RULE_04
            end else if (ctrl_r[CTL_EN_B]) begin // RULE_11
                drv_o[i] = val_b[i];
                drv_oe[i] = outb & ~(ctrl_r[CTL_OC_B] & val_b[i]); // RULE_04
            end
        end
    end
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pins_r <= '0;
        end else begin
            pins_r.o <= drv_o;
            pins_r.oe <= drv_oe;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~known;
            prdata <= '0;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    OFF_CTRL: prdata <= ctrl_r;
                    OFF_DATA: prdata <= 32'(xfer_r);
                    OFF_TIME: prdata <= {16'h0000, time_r};
                    OFF_STAMP: prdata <= {16'h0000, stamp_r};
                    OFF_COUNT: prdata <= {16'h0000, count_r}; // RULE_07
                    OFF_STAT: prdata <= {30'h0000_0000, pend_r, done_r};
                    OFF_COND: prdata <= 32'(cond_r);
                    OFF_PIN: prdata <= 32'(pin_i);
                    OFF_ID: prdata <= ID_VALUE;
                    default: prdata <= '0;
                endcase
            end
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_arm;
        armed;
    endsequence
    a_stamp_on_fire: assert property (@(posedge clk) disable iff (!rst_sync_n)
        fire |=> stamp_r == $past(count_r)) else $error("stamp mismatch"); // RULE_08
    a_count_wrap: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ptick && count_r == 16'hFFFF |=> count_r == 16'h0000) else $error("no wrap"); // RULE_15
    a_timed_match: assert property (@(posedge clk) disable iff (!rst_sync_n)
        fire && ctrl_r[CTL_TIMED] |-> count_r == time_r) else $error("early fire"); // RULE_16
    a_link_off: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ctrl_r[CTL_LINK] |=> pins_r.oe == '0) else $error("link pins driven"); // RULE_09
    a_oc_high: assert property (@(posedge clk) disable iff (!rst_sync_n)
        pins_r.oe[0] && ctrl_r[CTL_OC_A] && ctrl_r[CTL_EN_A] && $stable(ctrl_r)
        |-> !pins_r.o[0]) else $error("oc drives one"); // RULE_04
    a_one_cycle: assert property (@(posedge clk) disable iff (!rst_sync_n)
        psel && !penable |=> pready) else $error("slow answer"); // RULE_03
    a_arm_pending: assert property (@(posedge clk) disable iff (!rst_sync_n)
        s_arm |=> pend_r) else $error("not armed"); // RULE_07
    a_fire_done: assert property (@(posedge clk) disable iff (!rst_sync_n)
        fire |=> done_r && (!pend_r || $past(armed))) else $error("done not set"); // RULE_05
    a_input_nodrive: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !ctrl_r[CTL_OUT_A] && !ctrl_r[CTL_OUT_B] && $stable(ctrl_r)
        |-> pins_r.oe == '0) else $error("input driven"); // RULE_01
endmodule
